// ---- csio_pkg.sv ----
// Package for the configurable safety input/output mapper.
// Assumes a single 50 MHz clock domain and an APB register slave.
package csio_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_IN_FUNC   = 8'h00;
  localparam logic [7:0] OFF_OUT_FUNC  = 8'h04;
  localparam logic [7:0] OFF_GP_OUT    = 8'h08;
  localparam logic [7:0] OFF_PIN_STAT  = 8'h0c;
  localparam logic [7:0] OFF_SYS_STAT  = 8'h10;
  localparam logic [7:0] OFF_CMD       = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h1c;
  localparam logic [7:0] OFF_COMM      = 8'h20;
  // Function codes, two bits per input, three bits per output.
  localparam logic [1:0] IN_GP      = 2'h0;
  localparam logic [1:0] IN_ESTOP   = 2'h1;
  localparam logic [1:0] IN_OFFLINE = 2'h2;
  localparam logic [1:0] IN_HAND    = 2'h3;
  localparam logic [2:0] OUT_GP     = 3'h0;
  localparam logic [2:0] OUT_ESTOP  = 3'h1;
  localparam logic [2:0] OUT_MOTION = 3'h2;
  localparam logic [2:0] OUT_ERROR  = 3'h3;
  localparam logic [2:0] OUT_WARN   = 3'h4;
  localparam logic [2:0] OUT_COLL   = 3'h5;
  localparam logic [2:0] OUT_HAND   = 3'h6;
  localparam logic [2:0] OUT_TASK   = 3'h7;
  // Command register bit positions.
  localparam int CMD_ESTOP_SET = 0;
  localparam int CMD_ESTOP_CLR = 1;
  // Commissioning register: bit 8 enables forcing, bits 7:0 levels.
  localparam int COMM_EN = 8;
  // Input filter length in cycles and its time in ns.
  localparam int FILT_NS     = 100;
  localparam int CLK_NS      = 20;
  localparam int FILT_CYCLES = (FILT_NS + CLK_NS - 1) / CLK_NS;
  // Interrupt status bits.
  localparam int IRQ_ESTOP   = 0;
  localparam int IRQ_OFFLINE = 1;
  localparam int IRQ_HAND    = 2;
endpackage : csio_pkg

// ---- csio_mapper.sv ----
// Configurable safety input/output mapper with an APB register slave.
// Assumes field pins are asynchronous; motion controller status is on clk_i.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module csio_mapper #(
  parameter int N_CH = 8
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            psel_i,
  input  wire logic            penable_i,
  input  wire logic            pwrite_i,
  input  wire logic [7:0]      paddr_i,
  input  wire logic [31:0]     pwdata_i,
  output logic      [31:0]     prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  input  wire logic [N_CH-1:0] ctrl_in_i,
  output logic      [N_CH-1:0] ctrl_out_o,
  input  wire logic            stop_button_i,
  input  wire logic            host_stop_i,
  input  wire logic            prog_stop_i,
  input  wire logic            api_stop_i,
  input  wire logic            in_motion_i,
  input  wire logic            error_i,
  input  wire logic            warning_i,
  input  wire logic            collision_i,
  input  wire logic            task_running_i,
  output logic                 arm_power_off_o,
  output logic                 estop_state_o,
  output logic                 free_drag_o,
  output logic                 offline_start_o,
  output logic                 irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and wires.
  logic [2*N_CH-1:0] in_func;
  logic [3*N_CH-1:0] out_func;
  logic [N_CH-1:0]   gp_out;
  logic [N_CH:0]     comm;
  logic [2:0]        irq_stat;
  logic [2:0]        irq_mask;
  logic              estop_latch;
  logic [N_CH-1:0]   sync1;
  logic [N_CH-1:0]   sync2;
  logic [N_CH-1:0]   filt_in;
  logic [N_CH-1:0]   is_estop;
  logic [N_CH-1:0]   act_off;
  logic [N_CH-1:0]   act_hand;
  logic [N_CH-1:0]   next_out;
  logic              off_any;
  logic              off_prev;
  logic              pin_stop;
  logic              stop_cause;
  logic              stop_button_s1;
  logic              stop_button_s2;

  ////////////////////////////////////////////////////////////////////////////
  // Pins pass two flip-flops, then a stability filter per channel.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1          <= '1;
      sync2          <= '1;
      stop_button_s1 <= 1'b0;
      stop_button_s2 <= 1'b0;
    end else begin
      sync1          <= ctrl_in_i;
      sync2          <= sync1;
      stop_button_s1 <= stop_button_i;
      stop_button_s2 <= stop_button_s1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      logic [2:0] cnt;
      logic [1:0] fn;
      logic [1:0] pfn;
      logic [2:0] ofn;
      // A level is accepted only after it holds for the filter time.
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          cnt        <= 3'h0;
          filt_in[g] <= 1'b1;
        end else if (sync2[g] == filt_in[g]) begin
          cnt        <= 3'h0;
        end else if (cnt == 3'(csio_pkg::FILT_CYCLES - 1)) begin
          cnt        <= 3'h0;
          filt_in[g] <= sync2[g];
        end else begin
          cnt        <= cnt + 3'h1;
        end
      end
      // Pair partner is the channel with the lowest bit flipped.
      assign fn  = in_func[2*g +: 2];
      assign pfn = in_func[2*(g^1) +: 2];
      assign is_estop[g] = (fn == csio_pkg::IN_ESTOP) ||
                           (pfn == csio_pkg::IN_ESTOP);
      assign act_off[g]  = !is_estop[g] && (fn == csio_pkg::IN_OFFLINE) &&
                           !filt_in[g];
      assign act_hand[g] = !is_estop[g] && (fn == csio_pkg::IN_HAND) &&
                           !filt_in[g];
      // Output function selection, all status functions active low.
      assign ofn = out_func[3*g +: 3];
      always_comb begin
        case (ofn)
          csio_pkg::OUT_GP:     next_out[g] = gp_out[g];
          csio_pkg::OUT_ESTOP:  next_out[g] = !estop_latch;
          csio_pkg::OUT_MOTION: next_out[g] = !in_motion_i;
          csio_pkg::OUT_ERROR:  next_out[g] = !error_i;
          csio_pkg::OUT_WARN:   next_out[g] = !warning_i;
          csio_pkg::OUT_COLL:   next_out[g] = !collision_i;
          csio_pkg::OUT_HAND:   next_out[g] = !free_drag_o;
          csio_pkg::OUT_TASK:   next_out[g] = !task_running_i;
          default:              next_out[g] = 1'b1;
        endcase
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Stop sources and derived function levels.
  assign pin_stop   = |(is_estop & ~filt_in);
  assign stop_cause = stop_button_s2 | host_stop_i | prog_stop_i |
                      api_stop_i | pin_stop;
  assign off_any    = |act_off;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; every access completes in its first access cycle.
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        cmd_set;
  logic        cmd_clr;
  logic [31:0] rd_mux;
  logic [N_CH-1:0] gp_in_view;
  assign pready_o = 1'b1;
  assign addr_ok  = (paddr_i[1:0] == 2'h0) && (paddr_i <= csio_pkg::OFF_COMM);
  assign wr_en    = psel_i & penable_i & pwrite_i & addr_ok;
  assign rd_en    = psel_i & penable_i & !pwrite_i & addr_ok;
  assign pslverr_o = psel_i & penable_i & !addr_ok;
  assign cmd_set  = wr_en && (paddr_i == csio_pkg::OFF_CMD) &&
                    pwdata_i[csio_pkg::CMD_ESTOP_SET];
  assign cmd_clr  = wr_en && (paddr_i == csio_pkg::OFF_CMD) &&
                    pwdata_i[csio_pkg::CMD_ESTOP_CLR];
  // Only GP inputs are shown to programs; others read as one.
  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      gp_in_view[i] = (!is_estop[i] && in_func[2*i +: 2] == csio_pkg::IN_GP) ?
                      filt_in[i] : 1'b1;
    end
  end
  always_comb begin
    case (paddr_i)
      csio_pkg::OFF_IN_FUNC:  rd_mux = 32'(in_func);
      csio_pkg::OFF_OUT_FUNC: rd_mux = 32'(out_func);
      csio_pkg::OFF_GP_OUT:   rd_mux = 32'(gp_out);
      csio_pkg::OFF_PIN_STAT: rd_mux = {8'h00, gp_in_view, ctrl_out_o,
                                        filt_in};
      csio_pkg::OFF_SYS_STAT: rd_mux = {28'h0000000, offline_start_o,
                                        free_drag_o, pin_stop, estop_latch};
      csio_pkg::OFF_IRQ_STAT: rd_mux = {29'h0000000, irq_stat};
      csio_pkg::OFF_IRQ_MASK: rd_mux = {29'h0000000, irq_mask};
      csio_pkg::OFF_COMM:     rd_mux = 32'(comm);
      default:                rd_mux = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      in_func  <= '0;
      out_func <= '0;
      gp_out   <= '1;
      comm     <= '0;
      irq_mask <= 3'h0;
      prdata_o <= 32'h00000000;
    end else begin
      if (wr_en && paddr_i == csio_pkg::OFF_IN_FUNC)  in_func  <= pwdata_i[2*N_CH-1:0];
      if (wr_en && paddr_i == csio_pkg::OFF_OUT_FUNC) out_func <= pwdata_i[3*N_CH-1:0];
      if (wr_en && paddr_i == csio_pkg::OFF_GP_OUT)   gp_out   <= pwdata_i[N_CH-1:0];
      if (wr_en && paddr_i == csio_pkg::OFF_COMM)     comm     <= pwdata_i[N_CH:0];
      if (wr_en && paddr_i == csio_pkg::OFF_IRQ_MASK) irq_mask <= pwdata_i[2:0];
      if (psel_i && !penable_i) prdata_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop state: set by any source, left only by software while no cause.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      estop_latch <= 1'b0;
    end else if (stop_cause || cmd_set) begin
      estop_latch <= 1'b1;
    end else if (cmd_clr) begin
      estop_latch <= 1'b0;
    end
  end
  assign estop_state_o   = estop_latch;
  assign arm_power_off_o = stop_button_s2;

  ////////////////////////////////////////////////////////////////////////////
  // Function outputs, pin outputs and task start pulse.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_out_o      <= '1;
      free_drag_o     <= 1'b0;
      offline_start_o <= 1'b0;
      off_prev        <= 1'b0;
    end else begin
      ctrl_out_o      <= comm[csio_pkg::COMM_EN] ? comm[N_CH-1:0] : next_out;
      free_drag_o     <= |act_hand && !estop_latch;
      off_prev        <= off_any;
      offline_start_o <= off_any && !off_prev && !estop_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status; set wins over the clear-on-read.
  logic [2:0] irq_evt;
  logic       stat_rd;
  // Stop entry counts from any source, a software set included.
  assign irq_evt = {free_drag_o == 1'b0 && |act_hand, off_any && !off_prev,
                    (stop_cause || cmd_set) && !estop_latch};
  assign stat_rd = rd_en && (paddr_i == csio_pkg::OFF_IRQ_STAT);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (stat_rd ? 3'h0 : irq_stat) | irq_evt;
    end
  end
  assign irq_o = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // A host stop request is latched on the next edge.
  a_estop_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    host_stop_i |=> estop_latch) else $error("stop source did not latch");
  // A latched stop drives a stop-function output low.
  a_estop_pins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (estop_latch && !comm[csio_pkg::COMM_EN] &&
     out_func[2:0] == csio_pkg::OUT_ESTOP) |=> !ctrl_out_o[0])
    else $error("stop output not low");
  // A general-purpose output copies the written level.
  a_gp_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!comm[csio_pkg::COMM_EN] && out_func[2:0] == csio_pkg::OUT_GP)
    |=> ctrl_out_o[0] == $past(gp_out[0])) else $error("gp output wrong");
  // The motion output is the inverse of the motion status.
  a_motion_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!comm[csio_pkg::COMM_EN] && out_func[5:3] == csio_pkg::OUT_MOTION)
    |=> ctrl_out_o[1] == !$past(in_motion_i)) else $error("motion output wrong");
  // A low partner pin of a stop pair enters the stop state.
  a_pair_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_func[1:0] == csio_pkg::IN_ESTOP && !filt_in[1]) |=> estop_latch)
    else $error("paired stop input ignored");
  // Free drag follows an active hand-guiding input while not stopped.
  a_drag_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!estop_latch && |act_hand) |=> free_drag_o) else $error("drag not held");
  // Free drag ends as soon as no hand-guiding input is active.
  a_drag_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(|act_hand) |=> !free_drag_o) else $error("drag not ended");
  // A task start pulse needs a fresh falling edge of an offline input.
  a_offline_go: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    offline_start_o |-> $past(off_any) && !$past(off_prev))
    else $error("task start without edge");
  // A falling level is accepted only after five low samples.
  a_sync_filt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(filt_in[0]) |-> $past(sync2[0], 1) == 1'b0 && $past(sync2[0], 5) == 1'b0)
    else $error("input accepted without filtering");
  // The hand-guiding status output is low while free drag is on.
  a_hand_stat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!comm[csio_pkg::COMM_EN] && out_func[2:0] == csio_pkg::OUT_HAND)
    |=> ctrl_out_o[0] == !$past(free_drag_o)) else $error("drag status wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on redundant pairs and the remaining status functions.
  // Two stop outputs side by side always show the same level.
  a_estop_twin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!comm[csio_pkg::COMM_EN] && out_func[5:0] == {2{csio_pkg::OUT_ESTOP}})
    |=> ctrl_out_o[1] == ctrl_out_o[0]) else $error("stop output pair differs");
  // Two motion outputs side by side always show the same level.
  a_motion_twin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!comm[csio_pkg::COMM_EN] && out_func[5:0] == {2{csio_pkg::OUT_MOTION}})
    |=> ctrl_out_o[1] == ctrl_out_o[0]) else $error("motion output pair differs");
  // The error output is the inverse of the error status.
  a_error_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!comm[csio_pkg::COMM_EN] && out_func[2:0] == csio_pkg::OUT_ERROR)
    |=> ctrl_out_o[0] == !$past(error_i)) else $error("error output wrong");
  // The warning output is the inverse of the warning status.
  a_warn_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!comm[csio_pkg::COMM_EN] && out_func[2:0] == csio_pkg::OUT_WARN)
    |=> ctrl_out_o[0] == !$past(warning_i)) else $error("warning output wrong");
  // The collision output is the inverse of the collision status.
  a_coll_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!comm[csio_pkg::COMM_EN] && out_func[2:0] == csio_pkg::OUT_COLL)
    |=> ctrl_out_o[0] == !$past(collision_i)) else $error("collision output wrong");
  // The task output is low while stored tasks run.
  a_task_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!comm[csio_pkg::COMM_EN] && out_func[2:0] == csio_pkg::OUT_TASK)
    |=> ctrl_out_o[0] == !$past(task_running_i)) else $error("task output wrong");
  // A stop output ignores the level written for general use.
  a_gp_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!comm[csio_pkg::COMM_EN] && out_func[2:0] == csio_pkg::OUT_ESTOP && !estop_latch)
    |=> ctrl_out_o[0]) else $error("general level leaked to a stop output");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the input side.
  // With every pin high no input function may become active.
  a_high_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (&filt_in) |=> !free_drag_o && !offline_start_o)
    else $error("high input level asserted a function");
  // A rising level is accepted only after five high samples.
  a_sync_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(filt_in[0]) |-> $past(sync2[0], 1) && $past(sync2[0], 5))
    else $error("input released without filtering");
  // No task start and no free drag while the stop state holds.
  a_stop_no_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    estop_latch |=> !offline_start_o) else $error("task start while stopped");
  a_stop_no_drag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    estop_latch |=> !free_drag_o) else $error("free drag while stopped");
  // A task start pulse lasts exactly one cycle.
  a_offline_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    offline_start_o |=> !offline_start_o) else $error("task start pulse too long");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the stop latch, the interrupt and the register slave.
  // A stop button press always leaves the arm in the stop state.
  a_button_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(stop_button_s2) |=> estop_latch) else $error("button stop not latched");
  // A clear command is refused while any stop cause is present.
  a_clr_refused: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_clr && stop_cause) |=> estop_latch) else $error("stop cleared under a cause");
  // A stop entry event is never lost, even under a status read.
  a_irq_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_evt[0] |=> irq_stat[0]) else $error("stop event lost");
  // A status read with no new event leaves the status clear.
  a_read_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (stat_rd && irq_evt == 3'h0) |=> irq_stat == 3'h0) else $error("status not cleared");
  // Forced commissioning levels reach the pins on the next edge.
  a_force_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    comm[csio_pkg::COMM_EN] |=> ctrl_out_o == $past(comm[N_CH-1:0]))
    else $error("forced output level wrong");
  // The program view shows a non-general input as inactive.
  a_gp_view: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (psel_i && !penable_i && paddr_i == csio_pkg::OFF_PIN_STAT &&
     in_func[5:4] != csio_pkg::IN_GP) |=> prdata_o[18])
    else $error("non-general input exposed");
  // A refused address reads as zero and writes nothing.
  a_bad_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (psel_i && !penable_i && !addr_ok) |=> prdata_o == 32'h00000000)
    else $error("refused read returned data");
  a_bad_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (psel_i && penable_i && !addr_ok) |=> gp_out == $past(gp_out))
    else $error("refused access changed a register");

endmodule : csio_mapper

// ---- csio_field_model.sv ----
// Field equipment model: switches and relays wired to the mapper input pins.
// Assumes the bench asks for pin levels; switches are active low, idle high.
`timescale 1ns/1ps
module csio_field_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] want_i,
  output logic      [7:0] pins_o
);
  // Pins idle high, as an open switch with its pull-up leaves them.
  initial pins_o = 8'hff;
  // Each switch settles on the clock after the bench asks for it.
  always @(posedge clk_i) begin
    pins_o <= want_i;
  end
endmodule : csio_field_model

// ---- tb_configurable_safety_io_mapper.sv ----
// Self-checking bench for the safety input/output mapper.
// Assumes an APB slave that answers at once and pins settled in ten cycles.
`timescale 1ns/1ps
module tb_configurable_safety_io_mapper;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, arm_power_off_o, estop_state_o;
  logic        free_drag_o, offline_start_o, irq_o;
  logic [7:0]  ctrl_in_i, ctrl_out_o;
  logic [7:0]  want = 8'hff;
  logic [4:0]  stat = 5'h00;
  logic [3:0]  stops = 4'h0;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          n_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  csio_field_model i_csio_field_model (.clk_i(clk_i), .want_i(want), .pins_o(ctrl_in_i));
  csio_mapper i_csio_mapper (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .ctrl_in_i(ctrl_in_i),
    .ctrl_out_o(ctrl_out_o), .stop_button_i(stops[3]), .host_stop_i(stops[0]),
    .prog_stop_i(stops[1]), .api_stop_i(stops[2]), .in_motion_i(stat[4]), .error_i(stat[3]),
    .warning_i(stat[2]), .collision_i(stat[1]), .task_running_i(stat[0]),
    .arm_power_off_o(arm_power_off_o), .estop_state_o(estop_state_o),
    .free_drag_o(free_drag_o), .offline_start_o(offline_start_o), .irq_o(irq_o));
  ////////////////////////////////////////////////////////////////////////////////
  // The clock toggles every half period of 10 ns.
  initial forever #10 clk_i = ~clk_i;
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // Compares one value and counts it.
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // One APB transfer; waits for pready under a bound, takes data at that edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      stop_test();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  // Waits out the pin filter and output registers.
  task automatic settle(input int c);
    repeat (c) @(posedge clk_i);
  endtask : settle
  // Level an output of the given function should drive now.
  function automatic logic exp_lvl(input logic [2:0] c, input logic stp);
    case (c)
      csio_pkg::OUT_ESTOP:  return ~stp;
      csio_pkg::OUT_MOTION: return ~stat[4];
      csio_pkg::OUT_ERROR:  return ~stat[3];
      csio_pkg::OUT_WARN:   return ~stat[2];
      csio_pkg::OUT_COLL:   return ~stat[1];
      csio_pkg::OUT_TASK:   return ~stat[0];
      default:              return 1'b1;
    endcase
  endfunction : exp_lvl
  // A hang is cut short and counted.
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, register access, then each function in turn.
  initial begin
    logic [7:0] v;
    int cnt;
    void'($urandom(14230));
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    check("ctrl_out reset", 32'hff, {24'h0, ctrl_out_o});
    apb(1'b0, csio_pkg::OFF_GP_OUT, 32'h0);
    check("gp_out reset", 32'hff, rd);
    apb(1'b0, 8'h24, 32'h0);
    check("pslverr", 32'h1, {31'h0, err});
    // General-purpose outputs follow written levels.
    repeat (4) begin
      v = 8'($urandom);
      apb(1'b1, csio_pkg::OFF_GP_OUT, {24'h0, v});
      settle(3);
      check("ctrl_out gp", {24'h0, v}, {24'h0, ctrl_out_o});
    end
    // Every status function on all eight outputs.
    stat <= 5'($urandom);
    for (int k = 1; k < 8; k++) begin
      apb(1'b1, csio_pkg::OFF_OUT_FUNC, {8'h0, {8{k[2:0]}}});
      settle(3);
      check("ctrl_out func", {24'h0, {8{exp_lvl(k[2:0], 1'b0)}}}, {24'h0, ctrl_out_o});
    end
    // Each stop input and the set command enter the stop state, raise the interrupt, then clear.
    apb(1'b1, csio_pkg::OFF_OUT_FUNC, {8'h0, {8{csio_pkg::OUT_ESTOP}}});
    apb(1'b1, csio_pkg::OFF_IRQ_MASK, 32'h7);
    for (int k = 0; k < 5; k++) begin
      if (k < 4) stops[k] <= 1'b1;
      else apb(1'b1, csio_pkg::OFF_CMD, 32'h1);
      settle(12);
      check("estop_state", 32'h1, {31'h0, estop_state_o});
      check("arm_power_off", {31'h0, k == 3}, {31'h0, arm_power_off_o});
      check("ctrl_out estop", 32'h0, {24'h0, ctrl_out_o});
      check("irq", 32'h1, {31'h0, irq_o});
      apb(1'b0, csio_pkg::OFF_IRQ_STAT, 32'h0);
      check("irq stat", 32'h1, rd);
      if (k < 4) begin
        apb(1'b1, csio_pkg::OFF_CMD, 32'h2);
        check("estop held", 32'h1, {31'h0, estop_state_o});
      end
      stops <= 4'h0;
      settle(12);
      apb(1'b1, csio_pkg::OFF_CMD, 32'h2);
      settle(3);
      check("estop clear", 32'h0, {31'h0, estop_state_o});
      check("ctrl_out free", 32'hff, {24'h0, ctrl_out_o});
    end
    apb(1'b1, csio_pkg::OFF_GP_OUT, 32'h0);
    settle(3);
    check("gp ignored", 32'hff, {24'h0, ctrl_out_o});
    // Stop input on channel 0: glitch and unpaired pin ignored, partner pin stops.
    apb(1'b1, csio_pkg::OFF_IN_FUNC, {30'h0, csio_pkg::IN_ESTOP});
    want <= 8'hfd;
    settle(3);
    want <= 8'hf7;
    settle(12);
    check("glitch", 32'h0, {31'h0, estop_state_o});
    want <= 8'hfd;
    settle(12);
    check("pair stop", 32'h1, {31'h0, estop_state_o});
    want <= 8'hff;
    settle(12);
    apb(1'b1, csio_pkg::OFF_CMD, 32'h2);
    // Pin view: hand on channel 2, offline on channel 4, rest general.
    apb(1'b1, csio_pkg::OFF_IN_FUNC, 32'h230);
    v = (8'($urandom) | 8'h14) & 8'hfe;
    want <= v;
    settle(12);
    apb(1'b0, csio_pkg::OFF_PIN_STAT, 32'h0);
    check("pin status", {8'h0, v | 8'h14, 8'hff, v}, rd);
    want <= 8'hff;
    settle(12);
    apb(1'b0, csio_pkg::OFF_IRQ_STAT, 32'h0);
    // Hand guiding holds drag while low.
    apb(1'b1, csio_pkg::OFF_OUT_FUNC, {8'h0, {8{csio_pkg::OUT_HAND}}});
    want <= 8'hfb;
    settle(12);
    check("drag on", 32'h1, {31'h0, free_drag_o});
    check("ctrl_out hand", 32'h0, {24'h0, ctrl_out_o});
    apb(1'b0, csio_pkg::OFF_IRQ_STAT, 32'h0);
    check("irq drag", 32'h4, rd);
    want <= 8'hff;
    settle(12);
    check("drag off", 32'h0, {31'h0, free_drag_o});
    // Offline input gives one start pulse per falling level.
    cnt = 0;
    want <= 8'hef;
    repeat (20) begin
      @(posedge clk_i);
      cnt += int'(offline_start_o === 1'b1);
    end
    check("start pulses", 32'h1, cnt);
    apb(1'b0, csio_pkg::OFF_IRQ_STAT, 32'h0);
    check("irq offline", 32'h2, rd);
    want <= 8'hff;
    // Commissioning forces output levels.
    v = 8'($urandom);
    apb(1'b1, csio_pkg::OFF_COMM, {23'h0, 1'b1, v});
    settle(3);
    check("ctrl_out forced", {24'h0, v}, {24'h0, ctrl_out_o});
    apb(1'b1, csio_pkg::OFF_COMM, 32'h0);
    settle(3);
    check("ctrl_out release", 32'hff, {24'h0, ctrl_out_o});
    stop_test();
  end
endmodule : tb_configurable_safety_io_mapper
